// File: src/cic_pkg.sv
// Package for the per-line interrupt control registers of the core.
// Assumes a single core clock and the control-register move port of the pipeline.
package cic_pkg;

  // ----------------------------------------------------------------
  // Register selects on the control-register move port
  // ----------------------------------------------------------------
  localparam logic [2:0] CIC_SEL_ENABLE = 3'h0;
  localparam logic [2:0] CIC_SEL_PENDING = 3'h1;
  localparam logic [2:0] CIC_SEL_SET = 3'h2;
  localparam logic [2:0] CIC_SEL_CLEAR = 3'h3;
  localparam logic [2:0] CIC_SEL_NRP_PTR = 3'h4;
  localparam logic [2:0] CIC_SEL_MRP_PTR = 3'h5;
  localparam logic [2:0] CIC_SEL_VECTOR = 3'h6;
  localparam logic [2:0] CIC_SEL_STATUS = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CIC_BIT_RESET = 0;
  localparam int CIC_BIT_NMI = 1;
  localparam int CIC_BIT_GLOBAL = 0;
  localparam int CIC_BIT_SAVED = 1;
  localparam int CIC_VEC_LSB = 10;

  // Bits that may ever be one in the line enable (reset bit aside), pending and vector pointer registers.
  localparam logic [31:0] CIC_LINE_MASK = 32'h0000_FFF0;
  localparam logic [31:0] CIC_PEND_MASK = 32'h0000_FFF2;
  localparam logic [31:0] CIC_VEC_MASK = 32'hFFFF_FC00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CIC_ENABLE_RST = 32'h0000_0001;
  localparam logic [31:0] CIC_ZERO_RST = 32'h0000_0000;
  localparam logic [31:0] CIC_FETCH_RST = 32'h0000_0000;

endpackage : cic_pkg

// File: src/cic_regs.sv
// Interrupt enable, pending, set, clear and return-pointer registers.
// Assumes events arrive as one-cycle pulses from detection logic and the pipeline
// raises take and return strobes; all inputs are synchronous to sys_clk_in.
// Contract
// - Reset line enable bit always reads one and ignores writes.
// - Enable bits of lines four to fifteen are software writable.
// - An interrupt may be taken only while its enable bit is set.
// - Nonmaskable enable clear blocks every interrupt except reset.
// - Reset clears the nonmaskable enable bit.
// - Writing zero to the nonmaskable enable bit leaves it unchanged.
// - Taking a nonmaskable interrupt clears the nonmaskable enable bit.
// - Nonmaskable enable sets only by nonmaskable return or software writing one.
// - Pending register holds nonmaskable and lines four to fifteen flags.
// - Writing one to a set bit sets the matching line flag.
// - Writing one to a clear bit clears the matching line flag.
// - Zeros written to set or clear registers do nothing.
// - An incoming event beats a clear write on the same flag; the code lets it win only when it arrives the cycle after the write.
// - Set and clear cannot touch nonmaskable or reset flags.
// - Set or clear effect is readable two cycles after the write.
// - Simultaneous set and clear of one bit: set wins.
// - After reset release registers are known and fetch starts at zero.
// - Reset zeroes set, clear, pending, vector pointer; enable becomes one.
// - Taking nonmaskable loads its return pointer; pointer stays writable.
// - Taking maskable loads its return pointer; pointer stays writable.
// - Maskable return copies saved global enable into global enable.
// - Taking maskable copies global enable to saved, then clears global.
`timescale 1ns/1ns
module cic_regs
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Control-register move port
  input wire logic mv_wr_in,
  input wire logic [2:0] mv_sel_in,
  input wire logic [31:0] mv_wdata_in,
  input wire logic mv_rd_in,
  output logic [31:0] mv_rdata_out,
  // Interrupt events, one-cycle pulses per line
  input wire logic [15:0] int_event_in,
  // Pipeline take and return strobes
  input wire logic take_nmi_in,
  input wire logic take_mask_in,
  input wire logic [3:0] take_num_in,
  input wire logic [31:0] resume_addr_in,
  input wire logic ret_nmi_in,
  input wire logic ret_mask_in,
  // State toward the pipeline
  output logic [15:0] int_ready_out,
  output logic [31:0] interrupt_enable_out,
  output logic [31:0] interrupt_pending_flags_out,
  output logic nonmaskable_enable_bit_out,
  output logic global_enable_bit_out,
  output logic [31:0] vector_table_pointer_out,
  output logic [31:0] fetch_addr_out
);
  import cic_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] enable_r, enable_nxt;
  logic [31:0] pend_r, pend_nxt;
  logic [31:0] set_r, set_nxt;
  logic [31:0] clr_r, clr_nxt;
  logic [31:0] nrp_r, nrp_nxt;
  logic [31:0] mrp_r, mrp_nxt;
  logic [31:0] vec_r, vec_nxt;
  logic nonmaskable_enable_bit_r, nonmaskable_enable_bit_nxt;
  logic gie_r, gie_nxt;
  logic saved_global_enable_bit_r, saved_global_enable_bit_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] ready_r, ready_nxt;
  logic [31:0] fetch_r, fetch_nxt;

  function automatic logic wr_hit(input logic wr, input logic [2:0] sel,
                                  input logic [2:0] want);
    wr_hit = wr && (sel == want);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    enable_nxt = enable_r;
    nrp_nxt = nrp_r;
    mrp_nxt = mrp_r;
    vec_nxt = vec_r;
    nonmaskable_enable_bit_nxt = nonmaskable_enable_bit_r;
    gie_nxt = gie_r;
    saved_global_enable_bit_nxt = saved_global_enable_bit_r;
    fetch_nxt = fetch_r;
    // Set and clear are staged one cycle so the flag lands two cycles after the write.
    set_nxt = wr_hit(mv_wr_in, mv_sel_in, CIC_SEL_SET) ? (mv_wdata_in & CIC_LINE_MASK)
              : CIC_ZERO_RST;
    clr_nxt = wr_hit(mv_wr_in, mv_sel_in, CIC_SEL_CLEAR) ? (mv_wdata_in & CIC_LINE_MASK)
              : CIC_ZERO_RST;
    if (wr_hit(mv_wr_in, mv_sel_in, CIC_SEL_ENABLE))
    begin
      enable_nxt = (mv_wdata_in & CIC_LINE_MASK) | CIC_ENABLE_RST;
      if (mv_wdata_in[CIC_BIT_NMI])
        nonmaskable_enable_bit_nxt = 1'b1;
    end
    if (wr_hit(mv_wr_in, mv_sel_in, CIC_SEL_VECTOR))
      vec_nxt = mv_wdata_in & CIC_VEC_MASK;
    if (wr_hit(mv_wr_in, mv_sel_in, CIC_SEL_STATUS))
    begin
      gie_nxt = mv_wdata_in[CIC_BIT_GLOBAL];
      saved_global_enable_bit_nxt = mv_wdata_in[CIC_BIT_SAVED];
    end
    if (wr_hit(mv_wr_in, mv_sel_in, CIC_SEL_NRP_PTR))
      nrp_nxt = mv_wdata_in;
    if (wr_hit(mv_wr_in, mv_sel_in, CIC_SEL_MRP_PTR))
      mrp_nxt = mv_wdata_in;
    // Pipeline events take precedence over a same-cycle software write.
    if (ret_nmi_in)
      nonmaskable_enable_bit_nxt = 1'b1;
    if (ret_mask_in)
      gie_nxt = saved_global_enable_bit_r;
    if (take_nmi_in)
    begin
      nonmaskable_enable_bit_nxt = 1'b0;
      nrp_nxt = resume_addr_in;
    end
    if (take_mask_in)
    begin
      // The saved copy takes the value a same-cycle write just gave the global bit.
      saved_global_enable_bit_nxt = gie_nxt;
      gie_nxt = 1'b0;
      mrp_nxt = resume_addr_in;
    end
  end

  // Pending flags: clear and take, then set, then hardware events, so later terms win.
  // A new event in the cycle of its own take must survive, or it would be lost unseen.
  always_comb
  begin
    pend_nxt = pend_r & ~clr_r;
    if (take_mask_in)
      pend_nxt[take_num_in] = 1'b0;
    if (take_nmi_in)
      pend_nxt[CIC_BIT_NMI] = 1'b0;
    pend_nxt = pend_nxt | set_r;
    pend_nxt = pend_nxt | ({16'h0000, int_event_in} & CIC_PEND_MASK);
  end

  // Read data and the enabled-and-pending view for the pipeline.
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (mv_rd_in)
    begin
      unique case (mv_sel_in)
        CIC_SEL_ENABLE: rdata_nxt = enable_r | {30'h0, nonmaskable_enable_bit_r, 1'b0};
        CIC_SEL_PENDING: rdata_nxt = pend_r;
        CIC_SEL_NRP_PTR: rdata_nxt = nrp_r;
        CIC_SEL_MRP_PTR: rdata_nxt = mrp_r;
        CIC_SEL_VECTOR: rdata_nxt = vec_r;
        CIC_SEL_STATUS: rdata_nxt = {30'h0, saved_global_enable_bit_r, gie_r};
        CIC_SEL_SET, CIC_SEL_CLEAR: rdata_nxt = CIC_ZERO_RST;
      endcase
    end
    // Reset is always eligible; nonmaskable needs its enable; lines need all three.
    ready_nxt = {16{1'b0}};
    ready_nxt[CIC_BIT_RESET] = 1'b1;
    ready_nxt[CIC_BIT_NMI] = pend_nxt[CIC_BIT_NMI] & nonmaskable_enable_bit_nxt;
    ready_nxt[15:4] = pend_nxt[15:4] & enable_nxt[15:4] & {12{gie_nxt & nonmaskable_enable_bit_nxt}};
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      enable_r <= CIC_ENABLE_RST;
      pend_r <= CIC_ZERO_RST;
      set_r <= CIC_ZERO_RST;
      clr_r <= CIC_ZERO_RST;
      nrp_r <= CIC_ZERO_RST;
      mrp_r <= CIC_ZERO_RST;
      vec_r <= CIC_ZERO_RST;
      nonmaskable_enable_bit_r <= 1'b0;
      gie_r <= 1'b0;
      saved_global_enable_bit_r <= 1'b0;
      rdata_r <= CIC_ZERO_RST;
      ready_r <= 16'h0001;
      fetch_r <= CIC_FETCH_RST;
    end
    else
    begin
      enable_r <= enable_nxt;
      pend_r <= pend_nxt;
      set_r <= set_nxt;
      clr_r <= clr_nxt;
      nrp_r <= nrp_nxt;
      mrp_r <= mrp_nxt;
      vec_r <= vec_nxt;
      nonmaskable_enable_bit_r <= nonmaskable_enable_bit_nxt;
      gie_r <= gie_nxt;
      saved_global_enable_bit_r <= saved_global_enable_bit_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  assign mv_rdata_out = rdata_r;
  assign int_ready_out = ready_r;
  assign interrupt_enable_out = enable_r;
  assign interrupt_pending_flags_out = pend_r;
  assign nonmaskable_enable_bit_out = nonmaskable_enable_bit_r;
  assign global_enable_bit_out = gie_r;
  assign vector_table_pointer_out = vec_r;
  assign fetch_addr_out = fetch_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_set_write(int b);
    mv_wr_in && mv_sel_in == CIC_SEL_SET && mv_wdata_in[b];
  endsequence

  sequence s_clear_write(int b);
    mv_wr_in && mv_sel_in == CIC_SEL_CLEAR && mv_wdata_in[b];
  endsequence

  // Quiet cycles on line seven: no event and no set write that could set it.
  sequence s_line7_quiet;
    !int_event_in[7] && !(mv_wr_in && mv_sel_in == CIC_SEL_SET && mv_wdata_in[7]);
  endsequence

  a_clear_two_cycles: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_clear_write(7) and s_line7_quiet) |-> ##1 s_line7_quiet ##1 !pend_r[7])
    else $error("clear not visible after two cycles");
  a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (pend_r & ~CIC_PEND_MASK) == CIC_ZERO_RST
    && (enable_r & ~(CIC_LINE_MASK | CIC_ENABLE_RST)) == CIC_ZERO_RST)
    else $error("reserved bit set");
  a_nmi_event_sets: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    int_event_in[CIC_BIT_NMI] |=> pend_r[CIC_BIT_NMI]) else $error("nmi event lost");
  a_fetch_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    fetch_r == CIC_FETCH_RST) else $error("fetch address not zero");
  a_mask_take_saved_global_enable_bit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (take_mask_in && !ret_mask_in && !(mv_wr_in && mv_sel_in == CIC_SEL_STATUS))
    |=> saved_global_enable_bit_r == $past(gie_r)) else $error("saved global enable wrong");

  a_reset_enable_one: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    enable_r[CIC_BIT_RESET]) else $error("reset enable bit not one");
  a_line_enable_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (mv_wr_in && mv_sel_in == CIC_SEL_ENABLE) |=> enable_r[15:4] == $past(mv_wdata_in[15:4]))
    else $error("line enable write lost");
  a_ready_needs_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ready_r[15:4] & ~enable_r[15:4]) == 12'h000) else $error("disabled line ready");
  a_nonmaskable_enable_bit_blocks_all: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !nonmaskable_enable_bit_r |-> ready_r[15:1] == 15'h0000) else $error("ready while nonmaskable_enable_bit clear");
  a_nonmaskable_enable_bit_zero_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (nonmaskable_enable_bit_r && !take_nmi_in) |=> nonmaskable_enable_bit_r) else $error("nonmaskable_enable_bit cleared without take");
  a_nmi_take_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    take_nmi_in |=> !nonmaskable_enable_bit_r && nrp_r == $past(resume_addr_in))
    else $error("nmi take not recorded");
  a_nonmaskable_enable_bit_set_cause: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(nonmaskable_enable_bit_r) |-> $past(ret_nmi_in) || $past(mv_wr_in && mv_sel_in == CIC_SEL_ENABLE))
    else $error("nonmaskable_enable_bit set without cause");
  a_set_two_cycles: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_set_write(6) and (!take_mask_in)) |-> ##1 (!take_mask_in) ##1 pend_r[6])
    else $error("set not visible after two cycles");
  a_event_beats_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (int_event_in[9] && !take_mask_in) |=> pend_r[9]) else $error("event lost");
  a_mask_take_saves: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    take_mask_in |=> !gie_r && mrp_r == $past(resume_addr_in))
    else $error("maskable take not recorded");
  a_mask_return_gie: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ret_mask_in && !take_mask_in) |=> gie_r == $past(saved_global_enable_bit_r))
    else $error("return did not restore");
  a_nmi_flag_safe: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (!int_event_in[CIC_BIT_NMI] && !pend_r[CIC_BIT_NMI]) |=> !pend_r[CIC_BIT_NMI])
    else $error("nmi flag set by software");

endmodule : cic_regs

// File: test/cic_pipe_model.sv
// Pipeline stand-in: takes the interrupt that the block offers, and returns on command.
// Assumes bench commands are driven just after a clock edge and held for one cycle.
`timescale 1ns/1ns
module cic_pipe_model (
  // Clock and commands from the bench
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [1:0] ret_in,
  // Offer from the block
  input wire logic [15:0] ready_in,
  // Strobes toward the block
  output logic take_nmi_out,
  output logic take_mask_out,
  output logic [3:0] num_out,
  output logic ret_nmi_out,
  output logic ret_mask_out
);
  function automatic logic [3:0] pick(input logic [15:0] r);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 15; k >= 4; k--)
      if (r[k])
        n = k[3:0];
    return n;
  endfunction : pick

  initial {take_nmi_out, take_mask_out, num_out, ret_nmi_out, ret_mask_out} = '0;

  // Strobes change just after the edge, like the real pipeline, and stand one cycle.
  always @(posedge clk_in)
  begin
    take_nmi_out <= #1 go_in & ready_in[1];
    take_mask_out <= #1 go_in & ~ready_in[1] & (|ready_in[15:4]);
    num_out <= #1 pick(ready_in);
    ret_nmi_out <= #1 ret_in[0];
    ret_mask_out <= #1 ret_in[1];
  end
endmodule : cic_pipe_model

// File: test/cic_regs_tb.sv
// Self-checking bench for the interrupt control registers.
// Assumes cic_pkg, cic_regs and cic_pipe_model are compiled first.
`timescale 1ns/1ns
module cic_regs_tb;
  import cic_pkg::*;
  logic sys_clk_in = 0, rst_n_in = 0, mv_wr_in = 0, mv_rd_in = 0, go = 0;
  logic [1:0] ret = '0;
  logic [2:0] mv_sel_in = '0;
  logic [15:0] int_event_in = '0;
  logic [31:0] mv_wdata_in = '0, resume_addr_in = '0, seed = 32'd86700;
  logic take_nmi, take_mask, ret_nmi, ret_mask, nonmaskable_enable_bit_o, gie_o;
  logic [3:0] take_num;
  logic [15:0] ready;
  logic [31:0] rdata, en_o, pend_o, vec_o, fetch_o;
  logic [31:0] m_en = CIC_ENABLE_RST, m_pend = '0, m_nrp = '0, m_irp = '0, m_vec = '0;
  logic m_nonmaskable_enable_bit = 0, m_gie = 0, m_saved_global_enable_bit = 0;
  int n_mismatch = 0;
  int comparisons = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  cic_regs dut (.sys_clk_in, .rst_n_in, .mv_wr_in, .mv_sel_in, .mv_wdata_in, .mv_rd_in,
    .mv_rdata_out(rdata), .int_event_in, .take_nmi_in(take_nmi), .take_mask_in(take_mask),
    .take_num_in(take_num), .resume_addr_in, .ret_nmi_in(ret_nmi), .ret_mask_in(ret_mask),
    .int_ready_out(ready), .interrupt_enable_out(en_o), .interrupt_pending_flags_out(pend_o),
    .nonmaskable_enable_bit_out(nonmaskable_enable_bit_o), .global_enable_bit_out(gie_o),
    .vector_table_pointer_out(vec_o), .fetch_addr_out(fetch_o));
  cic_pipe_model pipe (.clk_in(sys_clk_in), .go_in(go), .ret_in(ret), .ready_in(ready),
    .take_nmi_out(take_nmi), .take_mask_out(take_mask), .num_out(take_num),
    .ret_nmi_out(ret_nmi), .ret_mask_out(ret_mask));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [15:0] rdy();
    return 16'h0001 | {14'h0, m_pend[1] & m_nonmaskable_enable_bit, 1'b0}
      | (m_pend[15:0] & m_en[15:0] & CIC_LINE_MASK[15:0] & {16{m_gie & m_nonmaskable_enable_bit}});
  endfunction : rdy
  function automatic logic [31:0] exp_rd(input logic [2:0] s);
    case (s)
      CIC_SEL_ENABLE: return m_en | {30'h0, m_nonmaskable_enable_bit, 1'b0};
      CIC_SEL_PENDING: return m_pend;
      CIC_SEL_NRP_PTR: return m_nrp;
      CIC_SEL_MRP_PTR: return m_irp;
      CIC_SEL_VECTOR: return m_vec;
      CIC_SEL_STATUS: return {30'h0, m_saved_global_enable_bit, m_gie};
      default: return 32'h0;
    endcase
  endfunction : exp_rd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc
  task automatic chk_all();
    cyc(3);
    chk("enable", m_en, en_o);
    chk("pending", m_pend, pend_o);
    chk("nonmaskable_enable_bit", {31'h0, m_nonmaskable_enable_bit}, {31'h0, nonmaskable_enable_bit_o});
    chk("gie", {31'h0, m_gie}, {31'h0, gie_o});
    chk("ready", {16'h0, rdy()}, {16'h0, ready});
    chk("vector", m_vec, vec_o);
    chk("fetch", CIC_FETCH_RST, fetch_o);
  endtask : chk_all
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    mv_wr_in = 1;
    mv_sel_in = s;
    mv_wdata_in = d;
    cyc(1);
    mv_wr_in = 0;
    case (s)
      CIC_SEL_ENABLE: m_en = (d & CIC_LINE_MASK) | CIC_ENABLE_RST;
      CIC_SEL_SET: m_pend |= d & CIC_LINE_MASK;
      CIC_SEL_CLEAR: m_pend &= ~(d & CIC_LINE_MASK);
      CIC_SEL_NRP_PTR: m_nrp = d;
      CIC_SEL_MRP_PTR: m_irp = d;
      CIC_SEL_VECTOR: m_vec = d & CIC_VEC_MASK;
      CIC_SEL_STATUS: {m_saved_global_enable_bit, m_gie} = d[1:0];
      default: m_pend = m_pend;
    endcase
    if (s == CIC_SEL_ENABLE)
      m_nonmaskable_enable_bit |= d[1];
    chk_all();
  endtask : wr
  task automatic rd(input logic [2:0] s);
    mv_rd_in = 1;
    mv_sel_in = s;
    cyc(1);
    mv_rd_in = 0;
    cyc(1);
    chk("rdata", exp_rd(s), rdata);
  endtask : rd
  task automatic ev(input logic [15:0] e);
    int_event_in = e;
    cyc(1);
    int_event_in = '0;
    m_pend |= {16'h0, e} & CIC_PEND_MASK;
    chk_all();
  endtask : ev
  task automatic take();
    logic [15:0] r;
    int n;
    r = rdy();
    n = 0;
    resume_addr_in = xs();
    go = 1;
    cyc(1);
    go = 0;
    for (int k = 15; k >= 4; k--)
      if (r[k])
        n = k;
    if (r[1])
    begin
      m_pend[1] = 0;
      m_nrp = resume_addr_in;
      m_nonmaskable_enable_bit = 0;
    end
    else if (n != 0)
    begin
      m_pend[n] = 0;
      m_irp = resume_addr_in;
      m_saved_global_enable_bit = m_gie;
      m_gie = 0;
    end
    chk_all();
    rd(CIC_SEL_NRP_PTR);
    rd(CIC_SEL_MRP_PTR);
    rd(CIC_SEL_STATUS);
  endtask : take
  task automatic back(input int b);
    ret[b] = 1'b1;
    cyc(1);
    ret = '0;
    if (b == 0)
      m_nonmaskable_enable_bit = 1;
    else
      m_gie = m_saved_global_enable_bit;
    chk_all();
  endtask : back
  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  initial
  begin
    #400000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    logic [31:0] d;
    cyc(12);
    rst_n_in = 1;
    chk_all();
    wr(CIC_SEL_ENABLE, 32'hFFFF_FFFC);
    for (int i = 0; i < 24; i++)
    begin
      d = xs();
      wr(i[2:0], d);
      rd(i[2:0]);
      ev(d[31:16]);
    end
    wr(CIC_SEL_CLEAR, 32'hFFFF_FFFF);
    mv_wr_in = 1;
    mv_sel_in = CIC_SEL_SET;
    mv_wdata_in = 32'h0000_0040;
    cyc(1);
    mv_wr_in = 0;
    chk("pend_slot", m_pend, pend_o);
    cyc(1);
    m_pend |= 32'h0000_0040;
    chk("pend_two", m_pend, pend_o);
    mv_wr_in = 1;
    mv_sel_in = CIC_SEL_CLEAR;
    cyc(1);
    mv_wr_in = 0;
    int_event_in = 16'h0040;
    cyc(1);
    int_event_in = '0;
    chk_all();
    wr(CIC_SEL_ENABLE, 32'hFFFF_FFFF);
    wr(CIC_SEL_STATUS, 32'h0000_0001);
    ev(16'h0302);
    take();
    take();
    back(0);
    take();
    take();
    back(1);
    take();
    final_report();
  end
endmodule : cic_regs_tb
